// ---- hdl/iocd_desc_if.sv ----
// Carrier between the dispatcher and its descriptor store
`timescale 1ns/1ns
`default_nettype none
interface iocd_desc_if;
  logic we;
  logic [2:0] ch;
  iocd_pkg::iocd_desc_t wdata;
  iocd_pkg::iocd_desc_t rdata;
  modport owner (output we, output ch, output wdata, input rdata);
  modport store (input we, input ch, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- hdl/iocd_desc_mem.sv ----
// Local memory of per-channel transfer descriptors
`timescale 1ns/1ns
`default_nettype none
`include "iocd_params.svh"
module iocd_desc_mem (
  input wire logic sys_clk, // System clock
  iocd_desc_if.store dport // Descriptor access
);
  import iocd_pkg::*;

  iocd_desc_t mem_q [`IOCD_NCH];

  // ----------------------------------------------------------------
  // One slot per channel, registered read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (dport.we) begin
      mem_q[dport.ch] <= dport.wdata;
    end
    dport.rdata <= mem_q[dport.ch];
  end
endmodule
`default_nettype wire

// ---- hdl/iocd_dispatcher.sv ----
// I/O channel job dispatcher top: job table, channels, interrupt stack
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "iocd_params.svh"
module iocd_dispatcher (
  input wire logic sys_clk, // System clock 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic mem_req, // Main memory request
  output logic mem_we, // Main memory write
  output logic [15:0] mem_addr, // Main memory word address
  output logic [31:0] mem_wdata, // Main memory write data
  input wire logic [31:0] mem_rdata, // Main memory read data
  input wire logic mem_ack, // Main memory done
  input wire logic [7:0] byte_rdy, // Peripheral byte offered, pins
  input wire logic [7:0] dev_err, // Peripheral error, pins
  output logic [7:0] start_line // Per-channel start to peripheral
);
  import iocd_pkg::*;

  iocd_desc_if dif ();
  iocd_desc_mem u_desc (
    .sys_clk(sys_clk),
    .dport(dif.store)
  );

  iocd_state_t state_q;
  logic enable_q;
  logic [15:0] jtp_q;
  logic [15:0] isloc_q;
  logic [9:0] islim_q;
  logic [9:0] iscnt_q;
  logic ovf_q;
  logic [31:0] word_q;
  logic [2:0] ch_q;
  logic [7:0] active_q;
  logic [7:0] pend_q;
  logic [7:0] term_q;
  logic [7:0] err_q;
  logic [15:0] arg_q [`IOCD_NCH];
  logic [31:0] job_q [`IOCD_NCH];
  logic [7:0] rdy_s1_q, rdy_s2_q, rdy_s3_q;
  logic [7:0] err_s1_q, err_s2_q;
  logic [2:0] entry;
  logic [2:0] wch;
  logic byte_any, term_any;
  logic [2:0] byte_ch, term_ch;
  logic [7:0] rdy_rise;
  logic mem_done;
  logic ovf_set;

  // ----------------------------------------------------------------
  // Pin synchronisers, then edge detect of byte_rdy on the second stage; dev_err is used as a level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_s1_q <= 8'h00;
      rdy_s2_q <= 8'h00;
      rdy_s3_q <= 8'h00;
      err_s1_q <= 8'h00;
      err_s2_q <= 8'h00;
    end else begin
      rdy_s1_q <= byte_rdy;
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
      err_s1_q <= dev_err;
      err_s2_q <= err_s1_q;
    end
  end
  assign rdy_rise = rdy_s2_q & ~rdy_s3_q;

  // Fixed priority: lowest channel number wins
  always_comb begin
    byte_any = 1'b0;
    byte_ch = 3'h0;
    term_any = 1'b0;
    term_ch = 3'h0;
    for (int i = `IOCD_NCH - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        byte_any = 1'b1;
        byte_ch = 3'(i);
      end
      if (term_q[i]) begin
        term_any = 1'b1;
        term_ch = 3'(i);
      end
    end
  end

  assign entry = word_q[`IOCD_TYPE_HI:`IOCD_TYPE_LO];
  assign wch = word_q[`IOCD_CH_HI:`IOCD_CH_LO];
  assign mem_done = mem_req & mem_ack;
  assign ovf_set = (state_q == IOCD_TERM_PUSH) && (iscnt_q >= islim_q);

  // ----------------------------------------------------------------
  // Dispatcher state machine
  // ----------------------------------------------------------------
  // Completions first, then bytes, then new jobs: keeps peripherals
  // from overrunning while the table is long.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IOCD_IDLE;
      ch_q <= 3'h0;
      word_q <= `IOCD_RST_WORD;
    end else begin
      case (state_q)
        IOCD_IDLE: begin
          if (term_any) begin
            ch_q <= term_ch;
            state_q <= IOCD_TERM_STAT;
          end else if (byte_any) begin
            ch_q <= byte_ch;
            state_q <= IOCD_BYTE_RD;
          end else if (enable_q) begin
            state_q <= IOCD_FETCH;
          end
        end
        IOCD_FETCH: begin
          if (mem_done) begin
            word_q <= mem_rdata;
            state_q <= IOCD_DECODE;
          end
        end
        IOCD_DECODE: begin
          ch_q <= wch;
          if (entry == `IOCD_ENT_NEW_JOB) begin
            state_q <= IOCD_PARAM;
          end else if (entry == `IOCD_ENT_NEW_ARG && active_q[wch]) begin
            state_q <= IOCD_PARAM;
          end else begin
            state_q <= IOCD_IDLE;
          end
        end
        IOCD_PARAM: begin
          if (mem_done) begin
            state_q <= IOCD_IDLE;
          end
        end
        IOCD_BYTE_RD: begin
          state_q <= IOCD_BYTE_WR;
        end
        IOCD_BYTE_WR: begin
          state_q <= IOCD_IDLE;
        end
        IOCD_TERM_STAT: begin
          if (mem_done) begin
            state_q <= IOCD_TERM_PUSH;
          end
        end
        IOCD_TERM_PUSH: begin
          if (ovf_set || mem_done) begin
            state_q <= IOCD_IDLE;
          end
        end
        default: begin
          state_q <= IOCD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Main memory master
  // ----------------------------------------------------------------
  always_comb begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = jtp_q;
    mem_wdata = job_q[ch_q];
    if (state_q == IOCD_FETCH) begin
      mem_req = 1'b1;
    end else if (state_q == IOCD_PARAM) begin
      mem_req = 1'b1;
      mem_addr = 16'(word_q[`IOCD_ARG_HI:`IOCD_ARG_LO]);
    end else if (state_q == IOCD_TERM_STAT) begin
      mem_req = 1'b1;
      mem_we = 1'b1;
      mem_addr = arg_q[ch_q] + `IOCD_STAT_OFS;
      mem_wdata = {30'h0, err_q[ch_q] ? `IOCD_ST_ERR : `IOCD_ST_DONE};
    end else if (state_q == IOCD_TERM_PUSH && !ovf_set) begin
      mem_req = 1'b1;
      mem_we = 1'b1;
      mem_addr = isloc_q + 16'(iscnt_q);
    end
  end

  // ----------------------------------------------------------------
  // Descriptor store access
  // ----------------------------------------------------------------
  always_comb begin
    dif.we = 1'b0;
    dif.ch = ch_q;
    dif.wdata = dif.rdata;
    if (state_q == IOCD_PARAM && mem_done) begin
      dif.we = 1'b1;
      dif.wdata.count = mem_rdata[31:16];
      dif.wdata.status = 2'h0;
      dif.wdata.buf_addr = mem_rdata[15:0];
    end else if (state_q == IOCD_BYTE_WR) begin
      dif.we = 1'b1;
      dif.wdata.count = dif.rdata.count - 16'h0001;
      dif.wdata.buf_addr = dif.rdata.buf_addr + 16'h0001;
      if (dif.rdata.count == 16'h0001) begin
        dif.wdata.status = `IOCD_ST_DONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Job table pointer and interrupt stack registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      jtp_q <= `IOCD_RST_ADDR;
      isloc_q <= `IOCD_RST_ADDR;
      islim_q <= `IOCD_RST_LIM;
    end else if (state_q == IOCD_DECODE && entry == `IOCD_ENT_NEW_TABLE) begin
      jtp_q <= word_q[15:0];
    end else if (state_q == IOCD_DECODE) begin
      jtp_q <= jtp_q + 16'h0001;
      if (entry == `IOCD_ENT_NEW_STACK) begin
        isloc_q <= word_q[15:0];
        islim_q <= word_q[`IOCD_LIM_HI:`IOCD_LIM_LO];
      end
    end else if (reg_wr) begin
      if (reg_addr == `IOCD_REG_JTP) begin
        jtp_q <= reg_wdata[15:0];
      end else if (reg_addr == `IOCD_REG_ISLOC) begin
        isloc_q <= reg_wdata[15:0];
      end else if (reg_addr == `IOCD_REG_ISLIM) begin
        islim_q <= reg_wdata[9:0];
      end
    end
  end

  // Stack fill count and sticky overflow; hardware set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      iscnt_q <= `IOCD_RST_LIM;
      ovf_q <= 1'b0;
    end else begin
      if (state_q == IOCD_DECODE && entry == `IOCD_ENT_NEW_STACK) begin
        iscnt_q <= `IOCD_RST_LIM;
      end else if (state_q == IOCD_TERM_PUSH && mem_done) begin
        iscnt_q <= iscnt_q + 10'h001;
      end else if (reg_wr && reg_addr == `IOCD_REG_ISCNT) begin
        iscnt_q <= reg_wdata[9:0];
      end
      if (ovf_set) begin
        ovf_q <= 1'b1;
      end else if (reg_wr && reg_addr == `IOCD_REG_STAT && reg_wdata[0]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel state: active bit, start line, job word, argument base
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 8'h00;
      start_line <= 8'h00;
      for (int i = 0; i < `IOCD_NCH; i++) begin
        arg_q[i] <= `IOCD_RST_ADDR;
        job_q[i] <= `IOCD_RST_WORD;
      end
    end else if (state_q == IOCD_DECODE) begin
      if (entry == `IOCD_ENT_NEW_JOB) begin
        active_q[wch] <= 1'b1;
        job_q[wch] <= word_q;
        arg_q[wch] <= 16'(word_q[`IOCD_ARG_HI:`IOCD_ARG_LO]);
      end else if (entry == `IOCD_ENT_NEW_ARG && active_q[wch]) begin
        arg_q[wch] <= 16'(word_q[`IOCD_ARG_HI:`IOCD_ARG_LO]);
        job_q[wch][`IOCD_ARG_HI:`IOCD_ARG_LO] <= word_q[`IOCD_ARG_HI:`IOCD_ARG_LO];
      end else if (entry == `IOCD_ENT_STOP) begin
        active_q[wch] <= 1'b0;
        start_line[wch] <= 1'b0;
      end
    end else if (state_q == IOCD_PARAM && mem_done) begin
      start_line[ch_q] <= active_q[ch_q];
    end else if (state_q == IOCD_TERM_PUSH && (ovf_set || mem_done)) begin
      active_q[ch_q] <= 1'b0;
    end else if (state_q == IOCD_TERM_STAT) begin
      start_line[ch_q] <= 1'b0;
    end
  end

  // Byte requests and terminations pending, per channel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 8'h00;
      term_q <= 8'h00;
      err_q <= 8'h00;
    end else begin
      for (int i = 0; i < `IOCD_NCH; i++) begin
        if (rdy_rise[i] && start_line[i] && !term_q[i]) begin
          pend_q[i] <= 1'b1;
        end else if (state_q == IOCD_BYTE_RD && ch_q == 3'(i)) begin
          pend_q[i] <= 1'b0;
        end else if (term_q[i]) begin
          pend_q[i] <= 1'b0;
        end
        if (err_s2_q[i] && start_line[i] && !term_q[i]) begin
          term_q[i] <= 1'b1;
          err_q[i] <= 1'b1;
        end else if (state_q == IOCD_BYTE_WR && ch_q == 3'(i) &&
                     dif.rdata.count == 16'h0001) begin
          term_q[i] <= 1'b1;
          err_q[i] <= 1'b0;
        end else if (state_q == IOCD_TERM_PUSH && ch_q == 3'(i) &&
                     (ovf_set || mem_done)) begin
          term_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
    end else if (reg_wr && reg_addr == `IOCD_REG_CTRL) begin
      enable_q <= reg_wdata[0];
    end
  end

  // Read data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `IOCD_RST_WORD;
    end else if (!reg_rd) begin
      reg_rdata <= `IOCD_RST_WORD;
    end else if (reg_addr == `IOCD_REG_CTRL) begin
      reg_rdata <= {31'h0, enable_q};
    end else if (reg_addr == `IOCD_REG_JTP) begin
      reg_rdata <= {16'h0, jtp_q};
    end else if (reg_addr == `IOCD_REG_ISLOC) begin
      reg_rdata <= {16'h0, isloc_q};
    end else if (reg_addr == `IOCD_REG_ISLIM) begin
      reg_rdata <= {22'h0, islim_q};
    end else if (reg_addr == `IOCD_REG_STAT) begin
      reg_rdata <= {8'h0, start_line, active_q, 6'h0, state_q != IOCD_IDLE, ovf_q};
    end else if (reg_addr == `IOCD_REG_ISCNT) begin
      reg_rdata <= {22'h0, iscnt_q};
    end else begin
      reg_rdata <= `IOCD_RST_WORD;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/iocd_params.svh ----
// Constants of the I/O channel job dispatcher
`ifndef IOCD_PARAMS_SVH
`define IOCD_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define IOCD_REG_CTRL 4'h0
`define IOCD_REG_JTP 4'h1
`define IOCD_REG_ISLOC 4'h2
`define IOCD_REG_ISLIM 4'h3
`define IOCD_REG_STAT 4'h4
`define IOCD_REG_ISCNT 4'h5

// ----------------------------------------------------------------
// Job word fields and entry type codes
// ----------------------------------------------------------------
`define IOCD_TYPE_HI 31
`define IOCD_TYPE_LO 29
`define IOCD_CH_HI 28
`define IOCD_CH_LO 26
`define IOCD_PGM_HI 25
`define IOCD_PGM_LO 13
`define IOCD_ARG_HI 12
`define IOCD_ARG_LO 0
`define IOCD_LIM_HI 25
`define IOCD_LIM_LO 16
`define IOCD_ENT_NEW_JOB 3'h1
`define IOCD_ENT_NEW_ARG 3'h2
`define IOCD_ENT_STOP 3'h3
`define IOCD_ENT_NEW_TABLE 3'h4
`define IOCD_ENT_NEW_STACK 3'h5

// ----------------------------------------------------------------
// Reset values, status codes and sizes
// ----------------------------------------------------------------
`define IOCD_RST_WORD 32'h0000_0000
`define IOCD_RST_ADDR 16'h0000
`define IOCD_RST_LIM 10'h000
`define IOCD_ST_DONE 2'h1
`define IOCD_ST_ERR 2'h2
`define IOCD_NCH 8
`define IOCD_STAT_OFS 16'h0001

`endif

// ---- hdl/iocd_pkg.sv ----
// Types shared by the I/O channel job dispatcher
package iocd_pkg;
  typedef enum logic [3:0] {
    IOCD_IDLE, IOCD_FETCH, IOCD_DECODE, IOCD_PARAM, IOCD_BYTE_RD,
    IOCD_BYTE_WR, IOCD_TERM_STAT, IOCD_TERM_PUSH
  } iocd_state_t;

  // Local descriptor: byte count, status, buffer address
  typedef struct packed {
    logic [15:0] count;
    logic [1:0] status;
    logic [15:0] buf_addr;
  } iocd_desc_t;
endpackage

// ---- sim/iocd_dispatcher_bench.sv ----
// Self-checking bench of the I/O channel job dispatcher
`timescale 1ns/1ns
`default_nettype none
`include "iocd_params.svh"
module iocd_dispatcher_bench;
  import iocd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] byte_rdy = 8'h0;
  logic [7:0] dev_err = 8'h0;
  logic [3:0] lat = 4'h0;
  logic [31:0] reg_rdata, mem_rdata, mem_wdata, d;
  logic mem_req, mem_we, mem_ack;
  logic [15:0] mem_addr;
  logic [7:0] start_line;
  logic [7:0] seen_q = 8'h0;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  iocd_dispatcher iocd_dispatcher_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .byte_rdy(byte_rdy), .dev_err(dev_err), .start_line(start_line));
  iocd_mem_model iocd_mem_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // ----------------------------------------
  // Start-line history and hang guard
  // ----------------------------------------
  always @(posedge sys_clk) begin
    seen_q <= seen_q | start_line;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      conclude();
    end
  end

  function automatic logic [31:0] jw(input logic [2:0] t, input logic [2:0] c,
                                     input logic [12:0] a);
    return {t, c, 13'h0, a};
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register access; entered and left just after a clock edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] v,
                     output logic [31:0] q);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic pulse(input int c);
    byte_rdy[c] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    byte_rdy[c] <= 1'b0;
    repeat (16) @(posedge sys_clk);
  endtask

  task automatic wait_line(input int c, input logic v);
    for (int n = 0; n < 300 && start_line[c] !== v; n++) @(posedge sys_clk);
    #1 chk({31'h0, start_line[c]}, {31'h0, v});
    @(posedge sys_clk);
  endtask

  // Park the fetcher, then point it at a new table
  task automatic phase(input logic [15:0] a);
    acc(1'b1, `IOCD_REG_CTRL, 32'h0, d);
    repeat (20) @(posedge sys_clk);
    acc(1'b1, `IOCD_REG_JTP, {16'h0, a}, d);
    acc(1'b1, `IOCD_REG_CTRL, 32'h1, d);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) iocd_mem_model_inst.mem[i] = 32'h0;
    // Segments end in a link entry, self-linked or (at 8'h12) linked to the self-link at 8'h20, to park the fetcher
    iocd_mem_model_inst.mem[8'h10] = 32'ha002_0100;
    iocd_mem_model_inst.mem[8'h11] = jw(`IOCD_ENT_NEW_JOB, 3'h2, 13'h40);
    iocd_mem_model_inst.mem[8'h12] = jw(`IOCD_ENT_NEW_TABLE, 3'h0, 13'h20);
    iocd_mem_model_inst.mem[8'h20] = jw(`IOCD_ENT_NEW_TABLE, 3'h0, 13'h20);
    iocd_mem_model_inst.mem[8'h40] = 32'h0002_1234;
    iocd_mem_model_inst.mem[8'h30] = jw(`IOCD_ENT_NEW_JOB, 3'h5, 13'h50);
    iocd_mem_model_inst.mem[8'h31] = jw(`IOCD_ENT_STOP, 3'h5, 13'h0);
    // Unknown type code must be skipped, pointer still advancing
    iocd_mem_model_inst.mem[8'h32] = jw(3'h7, 3'h5, 13'h0);
    iocd_mem_model_inst.mem[8'h33] = jw(`IOCD_ENT_NEW_TABLE, 3'h0, 13'h33);
    iocd_mem_model_inst.mem[8'h50] = 32'h0003_0000;
    iocd_mem_model_inst.mem[8'h38] = jw(`IOCD_ENT_NEW_JOB, 3'h1, 13'h60);
    iocd_mem_model_inst.mem[8'h39] = jw(`IOCD_ENT_NEW_TABLE, 3'h0, 13'h39);
    iocd_mem_model_inst.mem[8'h60] = 32'h0005_0000;
    iocd_mem_model_inst.mem[8'h3c] = jw(`IOCD_ENT_NEW_JOB, 3'h3, 13'h70);
    iocd_mem_model_inst.mem[8'h3d] = jw(`IOCD_ENT_NEW_ARG, 3'h3, 13'h78);
    iocd_mem_model_inst.mem[8'h3e] = jw(`IOCD_ENT_NEW_TABLE, 3'h0, 13'h3e);
    iocd_mem_model_inst.mem[8'h70] = 32'h0005_0000;
    iocd_mem_model_inst.mem[8'h78] = 32'h0001_0000;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values, unmapped place included
    acc(1'b1, 4'hf, 32'hffff_ffff, d);
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, (i == 6) ? 4'hf : i[3:0], 32'h0, d);
      chk(d, 32'h0);
    end
    acc(1'b1, `IOCD_REG_JTP, 32'h10, d);
    acc(1'b0, `IOCD_REG_JTP, 32'h0, d);
    chk(d, 32'h10);
    // Enable and read back in consecutive cycles
    reg_wr <= 1'b1;
    reg_addr <= `IOCD_REG_CTRL;
    reg_wdata <= 32'h1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & 32'h1, 32'h1);
    @(posedge sys_clk);
    wait_line(2, 1'b1);
    acc(1'b0, `IOCD_REG_ISLOC, 32'h0, d);
    chk(d, 32'h100);
    acc(1'b0, `IOCD_REG_ISLIM, 32'h0, d);
    chk(d, 32'h2);
    pulse(2);
    chk({31'h0, start_line[2]}, 32'h1);
    lat <= 4'h3;
    pulse(2);
    wait_line(2, 1'b0);
    repeat (30) @(posedge sys_clk);
    chk(iocd_mem_model_inst.mem[8'h41], {30'h0, `IOCD_ST_DONE});
    chk(iocd_mem_model_inst.mem[8'h00], jw(`IOCD_ENT_NEW_JOB, 3'h2, 13'h40));
    chk(iocd_mem_model_inst.mem[8'h01], 32'h0);
    acc(1'b0, `IOCD_REG_ISCNT, 32'h0, d);
    chk(d, 32'h1);
    acc(1'b0, `IOCD_REG_JTP, 32'h0, d);
    chk(d, 32'h20);
    // Stop right behind a new job
    phase(16'h30);
    repeat (100) @(posedge sys_clk);
    chk({31'h0, seen_q[5]}, 32'h1);
    wait_line(5, 1'b0);
    acc(1'b0, `IOCD_REG_STAT, 32'h0, d);
    chk(d & 32'h2000, 32'h0);
    acc(1'b0, `IOCD_REG_JTP, 32'h0, d);
    chk(d, 32'h33);
    // Peripheral error mid-transfer
    phase(16'h38);
    wait_line(1, 1'b1);
    dev_err[1] <= 1'b1;
    wait_line(1, 1'b0);
    dev_err[1] <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(iocd_mem_model_inst.mem[8'h61], {30'h0, `IOCD_ST_ERR});
    acc(1'b0, `IOCD_REG_ISCNT, 32'h0, d);
    chk(d, 32'h2);
    // New argument base, then a push into a full stack
    phase(16'h3c);
    wait_line(3, 1'b1);
    repeat (60) @(posedge sys_clk);
    pulse(3);
    wait_line(3, 1'b0);
    repeat (30) @(posedge sys_clk);
    chk(iocd_mem_model_inst.mem[8'h79], {30'h0, `IOCD_ST_DONE});
    chk(iocd_mem_model_inst.mem[8'h02], 32'h0);
    acc(1'b0, `IOCD_REG_STAT, 32'h0, d);
    chk(d & 32'h1, 32'h1);
    acc(1'b1, `IOCD_REG_STAT, 32'h1, d);
    acc(1'b0, `IOCD_REG_STAT, 32'h0, d);
    chk(d & 32'h1, 32'h0);
    conclude();
  end
endmodule

bind iocd_dispatcher iocd_dispatcher_properties iocd_dispatcher_properties_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .start_line(start_line));
`default_nettype wire

// ---- sim/iocd_dispatcher_properties.sv ----
// Port-level checker of the I/O channel job dispatcher
`timescale 1ns/1ns
`default_nettype none
module iocd_dispatcher_properties (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic mem_req, // Memory request
  input wire logic mem_we, // Memory write
  input wire logic [15:0] mem_addr, // Memory address
  input wire logic [31:0] mem_wdata, // Memory write data
  input wire logic mem_ack, // Memory done
  input wire logic [7:0] start_line // Channel start lines
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  a_rdata_after_read: assert property (
    reg_rdata != 32'h0 |-> $past(reg_rd)) else $error("read data outside its slot");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > 4'h5 |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_readback: assert property (
    reg_wr && reg_addr == 4'h0 ##1 reg_rd && !reg_wr && reg_addr == 4'h0
    |=> reg_rdata[0] == $past(reg_wdata[0], 2)) else $error("enable bit lost");
  a_stat_lines: assert property (
    reg_rd && reg_addr == 4'h4 |=> reg_rdata[23:16] == $past(start_line))
    else $error("status start lines wrong");
  // ----------------------------------------
  // Memory port and channel starts
  // ----------------------------------------
  a_req_addr_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("request dropped");
  a_req_data_hold: assert property (
    mem_req && !mem_ack |=> $stable(mem_we) && $stable(mem_wdata))
    else $error("write data moved");
  a_start_cause: assert property (
    (start_line & ~$past(start_line)) != 8'h0 |-> $past(mem_ack) && !$past(mem_we))
    else $error("start without argument read");
  a_start_single: assert property (
    $onehot0(start_line & ~$past(start_line))) else $error("two channels started");
endmodule
`default_nettype wire

// ---- sim/iocd_mem_model.sv ----
// Main memory model facing the dispatcher's memory port
`timescale 1ns/1ns
`default_nettype none
module iocd_mem_model (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic mem_req, // Request
  input wire logic mem_we, // Write qualifier
  input wire logic [15:0] mem_addr, // Word address
  input wire logic [31:0] mem_wdata, // Write data
  input wire logic [3:0] lat, // Answer delay in cycles
  output logic [31:0] mem_rdata, // Read data with ack
  output logic mem_ack // One-cycle done
);
  logic [31:0] mem [0:255];
  logic [3:0] wait_q;
  logic [31:0] junk_q;
  // ----------------------------------------
  // Answer after lat cycles, never twice on one request
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      mem_ack <= 1'b0;
      junk_q <= 32'h5a5a_0f0f;
    end else begin
      mem_ack <= 1'b0;
      junk_q <= {junk_q[30:0], ~junk_q[31]};
      if (mem_req && !mem_ack && wait_q >= lat) begin
        mem_ack <= 1'b1;
        wait_q <= 4'h0;
        if (mem_we) begin
          mem[mem_addr[7:0]] <= mem_wdata;
        end
      end else if (mem_req && !mem_ack) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
  // Outside the ack cycle a moving pattern, so stale data cannot pass
  assign mem_rdata = mem_ack ? mem[mem_addr[7:0]] : junk_q;
endmodule
`default_nettype wire
